// *** fan_drive_model.sv ***
// fan drive and processor hot source model
`timescale 1ns/1ns
`default_nettype none
module fan_drive_model (
  input wire logic sys_clk,
  input wire logic secondFanOutput,
  output var logic cpu1HotInput,
  output var logic cpu2HotInput
);
  initial begin
    cpu1HotInput = 1'b0;
    cpu2HotInput = 1'b0;
  end
  task automatic setHot(input logic a, input logic b);
    @(negedge sys_clk);
    cpu1HotInput = a;
    cpu2HotInput = b;
  endtask : setHot
  // one frame of 255 cycles sees every phase, so no alignment is needed
  task automatic measure(output int highs);
    highs = 0;
    repeat (3) @(negedge sys_clk);
    repeat (255) begin
      @(negedge sys_clk);
      if (secondFanOutput === 1'b1)
        highs++;
    end
  endtask : measure
endmodule : fan_drive_model
`default_nettype wire

// *** fan_pwm_monitor.sv ***
// assertion checker for the second fan output block
`timescale 1ns/1ns
`default_nettype none
module fan_pwm_monitor (
  input wire logic sys_clk,
  input wire logic rst,
  input wire fan_pwm_pkg::regReq_type regReq,
  input wire logic [7:0] regRdData,
  input wire logic configLock,
  input wire logic bindCpu1Hot,
  input wire logic bindCpu2Hot,
  input wire logic cpu1HotInput,
  input wire logic cpu2HotInput,
  input wire logic [3:0] sourceDutyCode,
  input wire logic secondFanOutput,
  input wire logic spinupActive,
  input wire logic hotLockFlag
);
  import fan_pwm_pkg::*;
  logic [2:0] ctl_q, ctl_d;
  logic [7:0] spin_q, spin_d;
  wire wrCtl = regReq.write && regReq.addr == OVERRIDE_POLARITY_LOCK_ADDR;
  wire wrSpin = regReq.write && regReq.addr == SPINUP_SETUP_ADDR;
  wire hot = (bindCpu1Hot && cpu1HotInput) || (bindCpu2Hot && cpu2HotInput);
  wire clr = wrCtl && !regReq.wrData[LOCK_FLAG_BIT];
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // shadow of the writable control bits
  always_comb begin
    ctl_d = ctl_q;
    spin_d = spin_q;
    if (wrCtl && !configLock)
      ctl_d = regReq.wrData[2:0];
    if (wrSpin && !configLock)
      spin_d = regReq.wrData;
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctl_q <= 3'h0;
      spin_q <= 8'h00;
    end else begin
      ctl_q <= ctl_d;
      spin_q <= spin_d;
    end
  end
  sequence readCd;
    regReq.read && regReq.addr == OVERRIDE_POLARITY_LOCK_ADDR;
  endsequence
  sequence readCe;
    regReq.read && regReq.addr == SPINUP_SETUP_ADDR;
  endsequence
  AST_NO_LOCK: assert property (
    !ctl_q[2] && !hotLockFlag |=> !hotLockFlag)
    else $error("lock flag set while disabled");
  AST_LOCK_SET: assert property (
    ctl_q[2] && hot |=> hotLockFlag)
    else $error("bound hot event did not lock");
  AST_LOCK_FULL: assert property (
    hotLockFlag && $past(hotLockFlag) && $stable(ctl_q[1]) |->
    secondFanOutput == !ctl_q[1])
    else $error("locked output not at full duty");
  AST_LOCK_HOLD: assert property (
    hotLockFlag && !clr |=> hotLockFlag)
    else $error("lock flag dropped without clear");
  AST_CLR_LOCKED: assert property (
    clr && configLock && !(ctl_q[2] && hot) |=> !hotLockFlag)
    else $error("lock flag not cleared under config lock");
  AST_SPIN_READ: assert property (
    readCd ##0 spinupActive |=> regRdData[7:4] == ZERO_CODE)
    else $error("override field nonzero during spin-up");
  AST_SPIN_OFF: assert property (
    $rose(spinupActive) |->
    $past(spin_q[3:0]) != ZERO_CODE && $past(spin_q[7:4]) != 4'h0)
    else $error("spin-up started while disabled");
  AST_CE_READ: assert property (
    readCe |=> regRdData == $past(spin_q))
    else $error("spin-up register readback wrong");
  AST_CD_READ: assert property (
    readCd |=> regRdData[3:0] == {$past(hotLockFlag), $past(ctl_q)})
    else $error("control register low bits wrong");
endmodule : fan_pwm_monitor
bind fan_pwm_override_spinup fan_pwm_monitor u_fan_pwm_monitor (.sys_clk,
  .rst, .regReq, .regRdData, .configLock, .bindCpu1Hot, .bindCpu2Hot,
  .cpu1HotInput, .cpu2HotInput, .sourceDutyCode, .secondFanOutput,
  .spinupActive, .hotLockFlag);
`default_nettype wire

// *** fan_pwm_override_spinup.sv ***
// second fan output: override, polarity, hot lock and spin-up
// Notes on behaviour
// - override enable set: output runs at the larger of the manual and source duty
// - polarity 0: full duty is steady high; polarity 1: steady low
// - only with lock enable set can a bound hot event set the lock flag
// - lock flag set holds the output at full duty
// - lock flag stays set until software writes zero to it
// - lock flag stays writable while the global configuration lock is set
// - 4-bit override duty code selects duty while override is active
// - reading the override field returns the code now driving the output
// - read may exceed the written code when another source asks more
// - override field reads zero while spin-up runs
// - 4-bit spin-up duty code sets duty during spin-up
// - spin-up duty code zero disables spin-up
// - duration code: bit 4 is its msb, bits 7:5 its low bits
// - duty rising from zero to non-zero starts spin-up for the duration
// - duration codes: off, 100..700 ms, 1, 2, 4 s, then 6..20 s
// - with several bound sources the largest requested duty wins
// - a hot input counts only when its binding bit is set
`timescale 1ns/1ns
`default_nettype none
module fan_pwm_override_spinup #(
  parameter int unsigned CyclesPerMs = fan_pwm_pkg::CYCLES_PER_MS
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire fan_pwm_pkg::regReq_type regReq,
  output logic [7:0] regRdData,
  input wire logic configLock,
  input wire logic bindCpu1Hot,
  input wire logic bindCpu2Hot,
  input wire logic cpu1HotInput,
  input wire logic cpu2HotInput,
  input wire logic [3:0] sourceDutyCode,
  output logic secondFanOutput,
  output logic spinupActive,
  output logic hotLockFlag
);
  import fan_pwm_pkg::*;

  // register state
  logic overrideEnable_q, overrideEnable_d;
  logic polarityInvert_q, polarityInvert_d;
  logic hotLockEnable_q, hotLockEnable_d;
  logic hotLockFlag_q, hotLockFlag_d;
  logic [3:0] overrideDutyCode_q, overrideDutyCode_d;
  logic [7:0] spinupSetup_q, spinupSetup_d;
  logic [7:0] rdData_q, rdData_d;

  // datapath state
  logic prevRequestZero_q, prevRequestZero_d;
  logic [7:0] pwmCount_q, pwmCount_d;
  logic pwmOut_q, pwmOut_d;

  logic writeCtl2;
  logic writeCtl3;
  logic boundHotEvent;
  logic [3:0] manualCode;
  logic [3:0] requestCode;
  logic [3:0] driveCode;
  logic [3:0] readDutyCode;
  logic [3:0] spinupDutyCode;
  logic [3:0] spinupDurationCode;
  logic [7:0] driveDuty;
  logic spinStart;
  logic spinAbort;
  logic spinBusy;

  function automatic logic [3:0] maxCode(input logic [3:0] a,
                                         input logic [3:0] b);
    return (a > b) ? a : b;
  endfunction : maxCode

  assign writeCtl2 = regReq.write &&
                     regReq.addr == OVERRIDE_POLARITY_LOCK_ADDR;
  assign writeCtl3 = regReq.write && regReq.addr == SPINUP_SETUP_ADDR;

  assign boundHotEvent = (bindCpu1Hot && cpu1HotInput) ||
                         (bindCpu2Hot && cpu2HotInput);

  assign spinupDurationCode = {spinupSetup_q[SPIN_DUR_MSB_BIT],
                               spinupSetup_q[SPIN_DUR_LOW_LSB +: 3]};
  assign spinupDutyCode = spinupSetup_q[SPIN_DUTY_LSB +: 4];

  assign manualCode = overrideEnable_q ? overrideDutyCode_q : ZERO_CODE;
  assign requestCode = maxCode(manualCode, sourceDutyCode);

  assign spinStart = prevRequestZero_q && requestCode != ZERO_CODE &&
                     spinupDutyCode != ZERO_CODE;
  // a fan that is asked to stop again must not keep spinning up
  assign spinAbort = requestCode == ZERO_CODE;

  spinup_timer #(
    .CyclesPerMs(CyclesPerMs)
  ) u_spinup_timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(spinStart),
    .abort(spinAbort),
    .lengthMs(durationMs(spinupDurationCode)),
    .busy(spinBusy)
  );

  always_comb begin
    if (hotLockFlag_q) begin
      driveCode = FULL_CODE;
    end else if (spinBusy) begin
      driveCode = spinupDutyCode;
    end else begin
      driveCode = requestCode;
    end
  end

  assign readDutyCode = spinBusy ? ZERO_CODE : driveCode;

  assign driveDuty = hotLockFlag_q ? FULL_DUTY : dutyOfCode(driveCode);

  // register writes
  always_comb begin
    overrideEnable_d = overrideEnable_q;
    polarityInvert_d = polarityInvert_q;
    hotLockEnable_d = hotLockEnable_q;
    hotLockFlag_d = hotLockFlag_q;
    overrideDutyCode_d = overrideDutyCode_q;
    spinupSetup_d = spinupSetup_q;
    if (writeCtl2 && !configLock) begin
      overrideEnable_d = regReq.wrData[OVERRIDE_EN_BIT];
      polarityInvert_d = regReq.wrData[POLARITY_BIT];
      hotLockEnable_d = regReq.wrData[LOCK_EN_BIT];
      overrideDutyCode_d = regReq.wrData[OVERRIDE_DUTY_LSB +: 4];
    end
    if (writeCtl2 && !regReq.wrData[LOCK_FLAG_BIT]) begin
      hotLockFlag_d = 1'b0;
    end
    // set needs lock enable
    // set after the clear so a same-cycle event is never lost
    if (hotLockEnable_q && boundHotEvent) begin
      hotLockFlag_d = 1'b1;
    end
    if (writeCtl3 && !configLock) begin
      spinupSetup_d = regReq.wrData;
    end
  end

  // register reads, answer one cycle after the strobe
  always_comb begin
    rdData_d = rdData_q;
    if (regReq.read) begin
      case (regReq.addr)
        OVERRIDE_POLARITY_LOCK_ADDR: begin
          rdData_d = {readDutyCode, hotLockFlag_q, hotLockEnable_q,
                      polarityInvert_q, overrideEnable_q};
        end
        SPINUP_SETUP_ADDR: rdData_d = spinupSetup_q;
        default: rdData_d = 8'h00;
      endcase
    end
  end

  // pwm frame; a full duty of 255 exceeds every count, so stays on
  always_comb begin
    prevRequestZero_d = requestCode == ZERO_CODE;
    if (pwmCount_q == PWM_LAST_COUNT) begin
      pwmCount_d = 8'h00;
    end else begin
      pwmCount_d = pwmCount_q + 8'h01;
    end
    pwmOut_d = (pwmCount_q < driveDuty) ^ polarityInvert_q;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      overrideEnable_q <= OVERRIDE_POLARITY_LOCK_RESET[OVERRIDE_EN_BIT];
      polarityInvert_q <= OVERRIDE_POLARITY_LOCK_RESET[POLARITY_BIT];
      hotLockEnable_q <= OVERRIDE_POLARITY_LOCK_RESET[LOCK_EN_BIT];
      hotLockFlag_q <= OVERRIDE_POLARITY_LOCK_RESET[LOCK_FLAG_BIT];
      overrideDutyCode_q <=
        OVERRIDE_POLARITY_LOCK_RESET[OVERRIDE_DUTY_LSB +: 4];
      spinupSetup_q <= SPINUP_SETUP_RESET;
      rdData_q <= 8'h00;
      prevRequestZero_q <= 1'b1;
      pwmCount_q <= 8'h00;
      pwmOut_q <= 1'b0;
    end else begin
      overrideEnable_q <= overrideEnable_d;
      polarityInvert_q <= polarityInvert_d;
      hotLockEnable_q <= hotLockEnable_d;
      hotLockFlag_q <= hotLockFlag_d;
      overrideDutyCode_q <= overrideDutyCode_d;
      spinupSetup_q <= spinupSetup_d;
      rdData_q <= rdData_d;
      prevRequestZero_q <= prevRequestZero_d;
      pwmCount_q <= pwmCount_d;
      pwmOut_q <= pwmOut_d;
    end
  end

  assign regRdData = rdData_q;
  assign secondFanOutput = pwmOut_q;
  assign spinupActive = spinBusy;
  assign hotLockFlag = hotLockFlag_q;

endmodule : fan_pwm_override_spinup
`default_nettype wire

// *** fan_pwm_pkg.sv ***
// constants, types and lookups for the second fan output control block
package fan_pwm_pkg;

  // register offsets
  localparam logic [7:0] OVERRIDE_POLARITY_LOCK_ADDR = 8'hCD;
  localparam logic [7:0] SPINUP_SETUP_ADDR = 8'hCE;

  // reset values
  localparam logic [7:0] OVERRIDE_POLARITY_LOCK_RESET = 8'h00;
  localparam logic [7:0] SPINUP_SETUP_RESET = 8'h00;

  // field positions, override/polarity/lock register
  localparam int OVERRIDE_EN_BIT = 0;
  localparam int POLARITY_BIT = 1;
  localparam int LOCK_EN_BIT = 2;
  localparam int LOCK_FLAG_BIT = 3;
  localparam int OVERRIDE_DUTY_LSB = 4;

  // field positions, spin-up register
  localparam int SPIN_DUTY_LSB = 0;
  localparam int SPIN_DUR_MSB_BIT = 4;
  localparam int SPIN_DUR_LOW_LSB = 5;

  // duty codes and pwm frame
  localparam logic [3:0] ZERO_CODE = 4'h0;
  localparam logic [3:0] FULL_CODE = 4'hF;
  localparam logic [7:0] FULL_DUTY = 8'hFF;
  localparam logic [7:0] PWM_LAST_COUNT = 8'hFE;
  localparam logic [7:0] DUTY_STEP = 8'h11;

  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int NS_PER_MS = 1000000;
  localparam int CYCLES_PER_MS = NS_PER_MS / CLK_PERIOD_NS;

  // spin-up durations in ms
  localparam int DUR_100_MS = 100;
  localparam int DUR_250_MS = 250;
  localparam int DUR_400_MS = 400;
  localparam int DUR_700_MS = 700;
  localparam int DUR_1_S_MS = 1000;
  localparam int DUR_2_S_MS = 2000;
  localparam int DUR_4_S_MS = 4000;
  localparam int DUR_6_S_MS = 6000;
  localparam int DUR_STEP_MS = 2000;

  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] wrData;
  } regReq_type;

  // duration code to milliseconds, zero means disabled
  function automatic logic [14:0] durationMs(input logic [3:0] code);
    int ms;
    ms = 0;
    case (code)
      4'h0: ms = 0;
      4'h1: ms = DUR_100_MS;
      4'h2: ms = DUR_250_MS;
      4'h3: ms = DUR_400_MS;
      4'h4: ms = DUR_700_MS;
      4'h5: ms = DUR_1_S_MS;
      4'h6: ms = DUR_2_S_MS;
      4'h7: ms = DUR_4_S_MS;
      default: ms = DUR_6_S_MS + (int'(code) - 8) * DUR_STEP_MS;
    endcase
    return ms[14:0];
  endfunction : durationMs

  // low-resolution code to duty on a 255 step frame
  function automatic logic [7:0] dutyOfCode(input logic [3:0] code);
    logic [11:0] prod;
    prod = {8'h00, code} * {4'h0, DUTY_STEP};
    return prod[7:0];
  endfunction : dutyOfCode

endpackage : fan_pwm_pkg

// *** spinup_timer.sv ***
// millisecond spin-up timer
`timescale 1ns/1ns
`default_nettype none
module spinup_timer #(
  parameter int unsigned CyclesPerMs = fan_pwm_pkg::CYCLES_PER_MS
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic abort,
  input wire logic [14:0] lengthMs,
  output logic busy
);
  import fan_pwm_pkg::*;

  typedef enum logic {TIMER_IDLE, TIMER_RUN} timerState_type;

  timerState_type state_q, state_d;
  logic [15:0] cycleCnt_q, cycleCnt_d;
  logic [14:0] msLeft_q, msLeft_d;

  always_comb begin
    state_d = state_q;
    cycleCnt_d = cycleCnt_q;
    msLeft_d = msLeft_q;
    case (state_q)
      TIMER_IDLE: begin
        if (start && lengthMs != 15'h0000) begin
          state_d = TIMER_RUN;
          cycleCnt_d = 16'h0000;
          msLeft_d = lengthMs;
        end
      end
      TIMER_RUN: begin
        if (abort) begin
          state_d = TIMER_IDLE;
        end else if (cycleCnt_q == 16'(CyclesPerMs - 1)) begin
          cycleCnt_d = 16'h0000;
          msLeft_d = msLeft_q - 15'h0001;
          if (msLeft_q == 15'h0001) begin
            state_d = TIMER_IDLE;
          end
        end else begin
          cycleCnt_d = cycleCnt_q + 16'h0001;
        end
      end
      default: state_d = TIMER_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= TIMER_IDLE;
      cycleCnt_q <= 16'h0000;
      msLeft_q <= 15'h0000;
    end else begin
      state_q <= state_d;
      cycleCnt_q <= cycleCnt_d;
      msLeft_q <= msLeft_d;
    end
  end

  assign busy = (state_q == TIMER_RUN);

endmodule : spinup_timer
`default_nettype wire

// *** tb_fan_pwm_override_spinup.sv ***
// self-checking bench for the second fan output block
`timescale 1ns/1ns
`default_nettype none
module tb_fan_pwm_override_spinup;
  import fan_pwm_pkg::*;
  localparam logic [7:0] CD = OVERRIDE_POLARITY_LOCK_ADDR;
  logic sys_clk, rst, configLock, bind1, bind2;
  logic hot1, hot2, fanOut, spinOn, lockFlag;
  logic [3:0] srcCode;
  logic [7:0] rdData;
  regReq_type req;
  int errors = 0;
  int compares = 0;
  fan_pwm_override_spinup #(.CyclesPerMs(2)) u_fan_pwm_override_spinup (
    .sys_clk, .rst, .regReq(req), .regRdData(rdData), .configLock,
    .bindCpu1Hot(bind1), .bindCpu2Hot(bind2), .cpu1HotInput(hot1),
    .cpu2HotInput(hot2), .sourceDutyCode(srcCode),
    .secondFanOutput(fanOut), .spinupActive(spinOn), .hotLockFlag(lockFlag));
  fan_drive_model u_fan_drive_model (.sys_clk, .secondFanOutput(fanOut),
    .cpu1HotInput(hot1), .cpu2HotInput(hot2));
  always #10 sys_clk = ~sys_clk;
  task automatic complete_run;
    if (errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    req = '{1'b1, 1'b0, a, d};
    @(negedge sys_clk);
    req.write = 1'b0;
  endtask : wr
  // settle first: the duty and read paths lag a change by a cycle
  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    repeat (3) @(negedge sys_clk);
    req.read = 1'b1;
    req.addr = a;
    @(negedge sys_clk);
    req.read = 1'b0;
    chk(rdData, exp);
  endtask : rdChk
  task automatic duty(input int exp);
    int h;
    u_fan_drive_model.measure(h);
    chk(h, exp);
  endtask : duty
  task automatic spinLen(output int n);
    int w;
    n = 0;
    w = 0;
    while (spinOn !== 1'b1 && w < 20) begin
      @(negedge sys_clk);
      w++;
    end
    while (spinOn === 1'b1) begin
      @(negedge sys_clk);
      n++;
      if (n > 20000) begin
        errors++;
        complete_run();
      end
    end
  endtask : spinLen
  task automatic t_reset;
    rdChk(CD, 8'h00);
    rdChk(SPINUP_SETUP_ADDR, 8'h00);
    rdChk(8'h10, 8'h00);
  endtask : t_reset
  task automatic t_override;
    logic [7:0] ctl [4] = '{8'h51, 8'h53, 8'hF1, 8'hF3};
    int want [4] = '{85, 170, 255, 0};
    for (int i = 0; i < 4; i++) begin
      wr(CD, ctl[i]);
      rdChk(CD, ctl[i]);
      duty(want[i]);
    end
    chk(spinOn, 1'b0);
    wr(CD, 8'h31);
    srcCode = 4'h9;
    rdChk(CD, 8'h91);
    duty(153);
    srcCode = 4'h0;
  endtask : t_override
  task automatic t_lock;
    wr(CD, 8'h21);
    bind1 = 1'b1;
    u_fan_drive_model.setHot(1'b1, 1'b0);
    rdChk(CD, 8'h21);
    chk(lockFlag, 1'b0);
    wr(CD, 8'h25);
    rdChk(CD, 8'hFD);
    chk(lockFlag, 1'b1);
    duty(255);
    bind1 = 1'b0;
    configLock = 1'b1;
    wr(CD, 8'h05);
    rdChk(CD, 8'h25);
    bind2 = 1'b1;
    rdChk(CD, 8'h25);
    u_fan_drive_model.setHot(1'b0, 1'b1);
    rdChk(CD, 8'hFD);
    bind2 = 1'b0;
    configLock = 1'b0;
    wr(CD, 8'h21);
    rdChk(CD, 8'h21);
    duty(34);
  endtask : t_lock
  task automatic t_spin;
    logic [7:0] su [4] = '{8'h43, 8'h13, 8'h40, 8'h03};
    int ms [4] = '{250, 6000, 0, 0};
    int n;
    for (int i = 0; i < 4; i++) begin
      wr(CD, 8'h00);
      wr(SPINUP_SETUP_ADDR, su[i]);
      wr(CD, 8'h61);
      fork
        spinLen(n);
        begin
          rdChk(CD, ms[i] != 0 ? 8'h01 : 8'h61);
          duty(ms[i] != 0 ? 51 : 102);
        end
      join
      chk(n, ms[i] * 2);
    end
  endtask : t_spin
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    req = '0;
    configLock = 1'b0;
    bind1 = 1'b0;
    bind2 = 1'b0;
    srcCode = 4'h0;
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    t_reset();
    t_override();
    t_lock();
    t_spin();
    complete_run();
  end
endmodule : tb_fan_pwm_override_spinup
`default_nettype wire
